// >>> rtl/flash_bus_cycle.sv
// Single asynchronous bus cycle engine: one write or one read on the flash pins
module flash_bus_cycle
  import flash_cmd_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              start,
  input  wire bus_cycle_t        cyc,
  input  wire logic [DATA_W-1:0] dq_in_sync,
  output flash_pins_t            pins,
  output logic                   done,
  output logic [DATA_W-1:0]      rd_data
);

  typedef enum logic [1:0] {CY_IDLE, CY_ACTIVE, CY_RECOVER} cy_state_t;

  cy_state_t         state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  flash_pins_t       pins_d;
  bus_cycle_t        cyc_q;
  logic [DATA_W-1:0] rd_data_q;
  logic              done_q;

  // Read data is sampled two cycles late through the synchroniser, so the
  // strobe is held long enough to cover that extra latency.
  localparam logic [CNT_W-1:0] ACT_WR = CNT_W'(WE_LOW_CYC);
  localparam logic [CNT_W-1:0] ACT_RD = CNT_W'(READ_ACC_CYC + 2);
  localparam logic [CNT_W-1:0] REC    = CNT_W'(WE_HIGH_CYC);

  wire logic cnt_zero = (cnt_q == '0);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_zero ? cnt_q : cnt_q - 1'b1;
    pins_d  = pins;
    unique case (state_q)
      CY_IDLE: begin
        if (start) begin
          state_d       = CY_ACTIVE;
          cnt_d         = cyc.rd ? ACT_RD : ACT_WR;
          pins_d.addr   = cyc.addr;
          pins_d.dq_out = cyc.data;
          pins_d.dq_oe  = ~cyc.rd;
          pins_d.ce_n   = 1'b0;
          pins_d.we_n   = cyc.rd;
          pins_d.oe_n   = ~cyc.rd;
        end
      end
      CY_ACTIVE: begin
        if (cnt_zero) begin
          state_d     = CY_RECOVER;
          cnt_d       = REC;
          pins_d.we_n = 1'b1;
          pins_d.oe_n = 1'b1;
          pins_d.ce_n = 1'b1;
        end
      end
      CY_RECOVER: begin
        if (cnt_zero) begin
          state_d      = CY_IDLE;
          pins_d.dq_oe = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= CY_IDLE;
      cnt_q     <= '0;
      pins      <= '{addr: '0, dq_out: '0, dq_oe: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      cyc_q     <= '0;
      rd_data_q <= '0;
      done_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pins    <= pins_d;
      done_q  <= (state_q == CY_RECOVER) && cnt_zero;
      if (start && state_q == CY_IDLE) begin
        cyc_q <= cyc;
      end
      if (state_q == CY_ACTIVE && cnt_zero && cyc_q.rd) begin
        rd_data_q <= dq_in_sync;
      end
    end
  end

  assign done    = done_q;
  assign rd_data = rd_data_q;

endmodule : flash_bus_cycle

// >>> rtl/flash_cmd_host.sv
// Host controller that issues flash command sequences over the parallel pins
module flash_cmd_host
  import flash_cmd_pkg::*;
#(
  parameter int unsigned BUF_WORDS = BUF_MAX_WORDS_X16
)(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  // User command port
  input  wire logic              cmd_valid,
  input  wire op_t               cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_data,
  input  wire logic [8:0]        cmd_count,
  input  wire logic              byte_mode,
  input  wire logic              in_bypass,
  output logic                   cmd_ready,
  input  wire logic              wdata_valid,
  input  wire logic [DATA_W-1:0] wdata,
  output logic                   wdata_ready,
  output logic                   cmd_done,
  output logic                   cmd_error,
  output logic [DATA_W-1:0]      status_data,
  // Flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n
);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_DONE
  } seq_state_t;

  seq_state_t        state_q, state_d;
  op_t               op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [8:0]        count_q;
  logic [8:0]        nwords_q;
  logic [3:0]        step_q;
  logic              last_q;
  logic              cmd_done_q, cmd_error_q, cmd_ready_q, wdata_ready_q;
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] dq_meta_q, dq_sync_q;

  bus_cycle_t        cyc;
  logic              cyc_last, cyc_wdata;
  flash_pins_t       pins;
  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rd_data;

  // ----------------------------------------------------------------
  // Input synchroniser for the data pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dq_meta_q <= '0;
      dq_sync_q <= '0;
    end else begin
      dq_meta_q <= flash_dq_in;
      dq_sync_q <= dq_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Command table: bus cycle for each step of each command
  // ----------------------------------------------------------------
  function automatic bus_cycle_t wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    wr = '{addr: a, data: d, rd: 1'b0};
  endfunction : wr

  // Steps 0 and 1 of buffer program, buffer abort and erase are the unlock prefix unless in bypass mode
  wire logic use_prefix = ~in_bypass;
  wire logic [3:0] s = step_q;
  wire logic       pre = use_prefix && (s < 4'd2);
  wire logic [3:0] t = use_prefix ? s - 4'd2 : s;
  wire bus_cycle_t prefix_cyc = (s == 4'd0) ? wr(ADDR_555, CODE_UNLOCK1)
                                            : wr(ADDR_2AA, CODE_UNLOCK2);
  // Buffer stream: t0 = 25 at sector, t1 = word count minus one, then data, then confirm
  wire logic [8:0] words_m1 = count_q - 9'd1;
  wire logic       in_data  = (t >= 4'd2) && (count_q != 9'd0);

  always_comb begin
    cyc       = wr(ADDR_ANY, CODE_RESET);
    cyc_last  = 1'b1;
    cyc_wdata = 1'b0;
    unique case (op_q)
      OP_BUF_PROGRAM: begin
        if (pre) begin
          cyc = prefix_cyc;
          cyc_last = 1'b0;
        end else if (t == 4'd0) begin
          cyc = wr(addr_q, CODE_WBUF);
          cyc_last = 1'b0;
        end else if (t == 4'd1) begin
          cyc = wr(addr_q, {7'h00, words_m1});
          cyc_last = 1'b0;
        end else if (in_data) begin
          // Words land at the sector base upward, in stream order
          cyc = wr(addr_q + ADDR_W'(nwords_q - count_q), wdata);
          cyc_last = 1'b0;
          cyc_wdata = 1'b1;
        end else begin
          cyc = wr(addr_q, CODE_CONFIRM);
        end
      end
      OP_BUF_ABORT: begin
        cyc = pre ? prefix_cyc : wr(ADDR_555, CODE_RESET);
        cyc_last = ~pre;
      end
      OP_ASO_EXIT:     cyc = wr(ADDR_ANY, CODE_RESET);
      OP_SUSPEND_LEG:  cyc = wr(ADDR_ANY, CODE_SUSP_LEG);
      OP_RESUME_LEG:   cyc = wr(ADDR_ANY, CODE_RES_LEG);
      OP_PSUSPEND_ENH: cyc = wr(ADDR_ANY, CODE_PSUSP_ENH);
      OP_PRESUME_ENH:  cyc = wr(ADDR_ANY, CODE_PRES_ENH);
      OP_BYPASS_EXIT: begin
        cyc = (s == 4'd0) ? wr(ADDR_ANY, CODE_EXIT1) : wr(ADDR_ANY, CODE_EXIT2);
        cyc_last = (s != 4'd0);
      end
      OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
        // Erase sequence repeats the prefix after 80 unless in bypass mode; the device does the
        // pre-programming to 0000h itself, so the host ends after the last write and does not wait.
        cyc_last = 1'b0;
        if (pre) cyc = prefix_cyc;
        else if (t == 4'd0) cyc = wr(ADDR_555, CODE_ERASE1);
        else if (use_prefix && t == 4'd1) cyc = wr(ADDR_555, CODE_UNLOCK1);
        else if (use_prefix && t == 4'd2) cyc = wr(ADDR_2AA, CODE_UNLOCK2);
        else begin
          cyc = (op_q == OP_SECTOR_ERASE) ? wr(addr_q, CODE_SECT_ER)
                                          : wr(ADDR_555, CODE_CHIP_ER);
          cyc_last = 1'b1;
        end
      end
      OP_NVREG_WRITE: begin
        // One write per command: each one wears the whole register array
        cyc = (s == 4'd0) ? wr(ADDR_ANY, CODE_NVREG_PGM) : wr(addr_q, data_q);
        cyc_last = (s != 4'd0);
      end
      OP_STATUS_READ: begin
        cyc = (s == 4'd0) ? wr(ADDR_555, CODE_STATUS)
                          : '{addr: addr_q, data: '0, rd: 1'b1};
        cyc_last = (s != 4'd0);
      end
      default: cyc = wr(ADDR_ANY, CODE_RESET);
    endcase
  end

  // ----------------------------------------------------------------
  // Acceptance checks
  // ----------------------------------------------------------------
  wire logic buf_too_big = (cmd_op == OP_BUF_PROGRAM) &&
                           ((cmd_count == 9'd0) ||
                            (byte_mode ? ({1'b0, cmd_count} > 10'(BUF_MAX_BYTES_X8))
                                       : ({1'b0, cmd_count} > 10'(BUF_WORDS))));
  wire logic accept     = (state_q == S_IDLE) && cmd_valid;
  wire logic stall_data = cyc_wdata && !wdata_valid;
  wire logic issue      = (state_q == S_ISSUE) && !stall_data;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE:  if (accept && !buf_too_big) state_d = S_ISSUE;
      S_ISSUE: if (issue) state_d = S_WAIT;
      S_WAIT:  if (cyc_done) state_d = last_q ? S_DONE : S_ISSUE;
      S_DONE:  state_d = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q       <= S_IDLE;
      op_q          <= OP_ASO_EXIT;
      addr_q        <= '0;
      data_q        <= '0;
      count_q       <= '0;
      nwords_q      <= '0;
      step_q        <= '0;
      last_q        <= 1'b0;
      cmd_done_q    <= 1'b0;
      cmd_error_q   <= 1'b0;
      cmd_ready_q   <= 1'b0;
      wdata_ready_q <= 1'b0;
      status_q      <= '0;
    end else begin
      state_q       <= state_d;
      cmd_done_q    <= (state_q == S_DONE) || (accept && buf_too_big);
      cmd_error_q   <= accept && buf_too_big;
      cmd_ready_q   <= (state_d == S_IDLE) && !(accept);
      wdata_ready_q <= 1'b0;
      if (accept) begin
        op_q    <= cmd_op;
        addr_q  <= cmd_addr;
        data_q  <= cmd_data;
        count_q <= cmd_count;
        nwords_q <= cmd_count;
        step_q  <= '0;
      end
      if (issue) begin
        last_q        <= cyc_last;
        step_q        <= step_q + ((cyc_wdata && count_q > 9'd1) ? 4'd0 : 4'd1);
        wdata_ready_q <= cyc_wdata;
        if (cyc_wdata) count_q <= count_q - 9'd1;
      end
      if (cyc_done && op_q == OP_STATUS_READ && last_q) status_q <= cyc_rd_data;
    end
  end

  flash_bus_cycle u_cycle (
    .sys_clk    (sys_clk),
    .nrst       (nrst),
    .start      (issue),
    .cyc        (cyc),
    .dq_in_sync (dq_sync_q),
    .pins       (pins),
    .done       (cyc_done),
    .rd_data    (cyc_rd_data)
  );

  assign cmd_ready    = cmd_ready_q;
  assign wdata_ready  = wdata_ready_q;
  assign cmd_done     = cmd_done_q;
  assign cmd_error    = cmd_error_q;
  assign status_data  = status_q;
  assign flash_addr   = pins.addr;
  assign flash_dq_out = pins.dq_out;
  assign flash_dq_oe  = pins.dq_oe;
  assign flash_ce_n   = pins.ce_n;
  assign flash_oe_n   = pins.oe_n;
  assign flash_we_n   = pins.we_n;

endmodule : flash_cmd_host

// >>> rtl/flash_cmd_pkg.sv
// Package: command codes, addresses, pin bundle and timing for the flash command host
package flash_cmd_pkg;

  localparam int unsigned ADDR_W = 26;
  localparam int unsigned DATA_W = 16;

  // Command data codes
  localparam logic [15:0] CODE_UNLOCK1   = 16'h00aa;
  localparam logic [15:0] CODE_UNLOCK2   = 16'h0055;
  localparam logic [15:0] CODE_CONFIRM   = 16'h0029;
  localparam logic [15:0] CODE_RESET     = 16'h00f0;
  localparam logic [15:0] CODE_SUSP_LEG  = 16'h00b0;
  localparam logic [15:0] CODE_RES_LEG   = 16'h0030;
  localparam logic [15:0] CODE_PSUSP_ENH = 16'h0051;
  localparam logic [15:0] CODE_PRES_ENH  = 16'h0050;
  localparam logic [15:0] CODE_EXIT1     = 16'h0090;
  localparam logic [15:0] CODE_EXIT2     = 16'h0000;
  localparam logic [15:0] CODE_STATUS    = 16'h0070;
  localparam logic [15:0] CODE_WBUF      = 16'h0025;
  localparam logic [15:0] CODE_ERASE1    = 16'h0080;
  localparam logic [15:0] CODE_SECT_ER   = 16'h0030;
  localparam logic [15:0] CODE_CHIP_ER   = 16'h0010;
  localparam logic [15:0] CODE_NVREG_PGM = 16'h00a0;

  // Word addresses of the unlock prefix, plus the don't-care address
  localparam logic [ADDR_W-1:0] ADDR_555 = 26'h0000555;
  localparam logic [ADDR_W-1:0] ADDR_2AA = 26'h00002aa;
  localparam logic [ADDR_W-1:0] ADDR_ANY = 26'h0000000;

  // Largest buffer load: in words when word-wide, in bytes when byte-wide (a full 512-byte load is refused)
  localparam int unsigned BUF_MAX_WORDS_X16 = 256;
  localparam int unsigned BUF_MAX_BYTES_X8  = 511;

  // Pin timing
  localparam int unsigned CLK_NS        = 20;
  localparam int unsigned WE_LOW_NS     = 35;
  localparam int unsigned WE_HIGH_NS    = 30;
  localparam int unsigned READ_ACC_NS   = 110;
  localparam int unsigned WE_LOW_CYC    = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WE_HIGH_CYC   = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned READ_ACC_CYC  = (READ_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W         = 4;

  // Host command opcodes
  typedef enum logic [3:0] {
    OP_BUF_PROGRAM,
    OP_ASO_EXIT,
    OP_SUSPEND_LEG,
    OP_RESUME_LEG,
    OP_PSUSPEND_ENH,
    OP_PRESUME_ENH,
    OP_BYPASS_EXIT,
    OP_SECTOR_ERASE,
    OP_CHIP_ERASE,
    OP_NVREG_WRITE,
    OP_STATUS_READ,
    OP_BUF_ABORT
  } op_t;

  // Bus pins toward the flash; data is a two-way pin
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
  } flash_pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              rd;
  } bus_cycle_t;

endpackage : flash_cmd_pkg

// >>> verif/flash_cmd_checker.sv
// Pin and handshake assertions for the flash command host
module flash_cmd_checker
  import flash_cmd_pkg::*;
#(
  parameter int unsigned BUF_WORDS = 256
)(
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              cmd_valid,
  input wire op_t               cmd_op,
  input wire logic [8:0]        cmd_count,
  input wire logic              byte_mode,
  input wire logic              cmd_ready,
  input wire logic              wdata_ready,
  input wire logic              cmd_done,
  input wire logic              cmd_error,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [DATA_W-1:0] flash_dq_out,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  strobe_excl_a: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and read strobes low together");
  write_select_a: assert property (!flash_we_n |-> !flash_ce_n && flash_dq_oe)
    else $error("write strobe without select or drive");
  read_release_a: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data driven during read");
  write_hold_a: assert property ($fell(flash_we_n) |=>
    (!flash_we_n && $stable(flash_addr) && $stable(flash_dq_out)) [*2] ##1 flash_we_n)
    else $error("write cycle shape wrong");
  read_hold_a: assert property ($fell(flash_oe_n) |=>
    (!flash_oe_n && !flash_ce_n && $stable(flash_addr)) [*6])
    else $error("read access cut short");
  refuse_fast_a: assert property (cmd_valid && cmd_ready && cmd_op == OP_BUF_PROGRAM &&
    (cmd_count == 9'h000 || (!byte_mode && cmd_count > BUF_WORDS)) |=>
    cmd_done && cmd_error && flash_ce_n)
    else $error("bad count not refused");
  error_done_a: assert property (cmd_error |-> cmd_done)
    else $error("error without done");
  done_pulse_a: assert property (cmd_done && !cmd_valid |=> !cmd_done)
    else $error("done longer than one cycle");
  idle_quiet_a: assert property (cmd_ready |-> flash_ce_n && flash_we_n)
    else $error("bus active while idle");
  busy_after_take_a: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("ready stays high after take");
  cover property (cmd_done && cmd_error);
  cover property ($fell(flash_oe_n));
  cover property (wdata_ready);
endmodule : flash_cmd_checker

// >>> verif/flash_model.sv
// Behavioural flash device answering the host controller pins
module flash_model
  import flash_cmd_pkg::*;
#(
  parameter int ACC_NS = 60
)(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  output logic      [DATA_W-1:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ADDR_W-1:0] wa[$];
  logic [DATA_W-1:0] wd[$];
  logic [DATA_W-1:0] last_q = 16'h0000;
  logic [DATA_W-1:0] prev_q = 16'hffff;
  logic              susp_q = 1'b0;
  logic              stat_q = 1'b0;
  logic              byp_q  = 1'b1;
  int                unl    = 0;
  int                nv_cycles = 0;
  wire  [DATA_W-1:0] rd_val = stat_q ? {8'h00, 1'b1, susp_q, 6'h00} : addr[15:0] ^ 16'h5a5a;
  // Released bus shows the inverse of the last value, never a stale copy
  assign #(ACC_NS) dq_in = (!ce_n && !oe_n) ? rd_val : ~last_q;
  // Select and write strobe rise in the same step; latch on whichever ends the write
  wire               wr_act = !ce_n && !we_n;
  always @(negedge wr_act) begin
    begin
      wa.push_back(addr);
      wd.push_back(dq_out);
      unl = (dq_out == CODE_UNLOCK1 && addr == ADDR_555) ? 1 :
            (unl == 1 && dq_out == CODE_UNLOCK2 && addr == ADDR_2AA) ? 2 : 0;
      if (dq_out == CODE_STATUS && addr == ADDR_555) stat_q <= 1'b1;
      if (dq_out == CODE_RESET) stat_q <= 1'b0;
      if (dq_out == CODE_SUSP_LEG || dq_out == CODE_PSUSP_ENH) susp_q <= 1'b1;
      if (dq_out == CODE_RES_LEG || dq_out == CODE_PRES_ENH) susp_q <= 1'b0;
      // Program and erase complete at once; pre-program is not visible here
      if (dq_out == CODE_CONFIRM || dq_out == CODE_CHIP_ER) susp_q <= 1'b0;
      if (prev_q == CODE_EXIT1 && dq_out == CODE_EXIT2) byp_q <= 1'b0;
      if (prev_q == CODE_NVREG_PGM) nv_cycles++;
      prev_q <= dq_out;
    end
  end
  always @(posedge oe_n) begin
    last_q <= rd_val;
    stat_q <= 1'b0;
  end
endmodule : flash_model

// >>> verif/tb.sv
// Self-checking bench for the flash command host
module tb
  import flash_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BUFW = 256;
  logic sys_clk, nrst, cmd_valid, byte_mode, in_bypass, cmd_ready, wdata_valid, wdata_ready;
  logic cmd_done, cmd_error, flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n, got_err;
  op_t  cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_addr, sa, ea[$];
  logic [DATA_W-1:0] cmd_data, wdata, status_data, flash_dq_out, flash_dq_in, ed[$];
  logic [DATA_W-1:0] wbuf[BUFW];
  logic [8:0]        cmd_count;
  bit                ec[$];
  bit                susp;
  int errors = 0, num_checks = 0, seed = 77, widx = 0, n, c0;
  op_t               ops[5] = '{OP_ASO_EXIT, OP_SUSPEND_LEG, OP_RESUME_LEG,
                                OP_PSUSPEND_ENH, OP_PRESUME_ENH};
  logic [DATA_W-1:0] codes[5] = '{CODE_RESET, CODE_SUSP_LEG, CODE_RES_LEG,
                                  CODE_PSUSP_ENH, CODE_PRES_ENH};
  flash_cmd_host #(.BUF_WORDS(BUFW)) flash_cmd_host_i (.sys_clk, .nrst, .cmd_valid, .cmd_op,
    .cmd_addr, .cmd_data, .cmd_count, .byte_mode, .in_bypass, .cmd_ready, .wdata_valid, .wdata,
    .wdata_ready, .cmd_done, .cmd_error, .status_data, .flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_oe_n, .flash_we_n);
  flash_model flash_model_i (.addr(flash_addr), .dq_out(flash_dq_out), .ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .dq_in(flash_dq_in));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  function automatic void ex(input logic [ADDR_W-1:0] a, input logic [15:0] d, input bit c);
    ea.push_back(a);
    ed.push_back(d);
    ec.push_back(c);
  endfunction : ex
  function automatic void pre();
    if (!in_bypass) begin
      ex(ADDR_555, CODE_UNLOCK1, 1'b1);
      ex(ADDR_2AA, CODE_UNLOCK2, 1'b1);
    end
  endfunction : pre
  task automatic issue(input op_t op, input logic [ADDR_W-1:0] a, input logic [8:0] cnt);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge sys_clk);
      k++;
    end
    flash_model_i.wa.delete();
    flash_model_i.wd.delete();
    widx = 0;
    cmd_op = op;
    cmd_addr = a;
    cmd_count = cnt;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    k = 0;
    while (cmd_done !== 1'b1 && k < 5000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 5000) check("done", 1, 0);
    got_err = cmd_error;
  endtask : issue
  task automatic verify();
    check("writes", ed.size(), flash_model_i.wd.size());
    for (int i = 0; i < ed.size(); i++) begin
      check("data", ed[i], flash_model_i.wd[i]);
      if (ec[i]) check("addr", ea[i], flash_model_i.wa[i]);
    end
    ea.delete();
    ed.delete();
    ec.delete();
  endtask : verify
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // ----------------------------------------
  // Clock, data stream and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Word held until consumed, so random stalls never lose or repeat data
  always @(negedge sys_clk) begin
    if (wdata_ready === 1'b1) widx++;
    wdata <= wbuf[widx % BUFW];
    wdata_valid <= ($random(seed) & 3) != 0;
  end
  initial begin
    #1000000;
    errors++;
    complete_run();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {nrst, cmd_valid, byte_mode, in_bypass} = '0;
    cmd_op = OP_ASO_EXIT;
    {cmd_addr, cmd_data, cmd_count} = '0;
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    for (int i = 0; i < 5; i++) begin
      ex(ADDR_ANY, codes[i], 1'b0);
      issue(ops[i], ADDR_ANY, 9'h000);
      verify();
      susp = (i == 1 || i == 3);
      ex(ADDR_555, CODE_STATUS, 1'b1);
      issue(OP_STATUS_READ, 26'(i * 64), 9'h000);
      verify();
      check("status", {8'h00, 1'b1, susp, 6'h00}, status_data);
    end
    ex(ADDR_ANY, CODE_EXIT1, 1'b0);
    ex(ADDR_ANY, CODE_EXIT2, 1'b0);
    issue(OP_BYPASS_EXIT, ADDR_ANY, 9'h000);
    verify();
    check("bypass", 0, flash_model_i.byp_q);
    pre();
    ex(ADDR_555, CODE_RESET, 1'b1);
    issue(OP_BUF_ABORT, ADDR_ANY, 9'h000);
    verify();
    for (int b = 0; b < 4; b++) begin
      in_bypass = b[0];
      sa = 26'($random(seed)) & 26'h3ff0000;
      pre();
      ex(ADDR_555, CODE_ERASE1, !in_bypass);
      pre();
      ex(b[1] ? ADDR_ANY : sa, b[1] ? CODE_CHIP_ER : CODE_SECT_ER, !b[1]);
      issue(b[1] ? OP_CHIP_ERASE : OP_SECTOR_ERASE, sa, 9'h000);
      verify();
    end
    for (int r = 0; r < 4; r++) begin
      n = (r == 0) ? 1 : (r == 1) ? BUFW : 2 + {$random(seed)} % 8;
      in_bypass = r[0];
      sa = 26'($random(seed)) & 26'h3ff0000;
      for (int k = 0; k < n; k++) wbuf[k] = 16'($random(seed));
      pre();
      ex(sa, CODE_WBUF, 1'b1);
      ex(sa, 16'(n - 1), 1'b1);
      for (int k = 0; k < n; k++) ex(sa + 26'(k), wbuf[k], 1'b1);
      ex(sa, CODE_CONFIRM, 1'b1);
      issue(OP_BUF_PROGRAM, sa, 9'(n));
      check("noerr", 0, got_err);
      verify();
    end
    for (int r = 0; r < 2; r++) begin
      byte_mode = r[0];
      issue(OP_BUF_PROGRAM, ADDR_ANY, r[0] ? 9'h000 : 9'(BUFW + 1));
      check("refused", 1, got_err);
      verify();
    end
    byte_mode = 1'b0;
    in_bypass = 1'b0;
    cmd_data = 16'($random(seed));
    c0 = flash_model_i.nv_cycles;
    issue(OP_NVREG_WRITE, 26'h0000010, 9'h000);
    check("nvcycle", c0 + 1, flash_model_i.nv_cycles);
    check("nvdata", cmd_data, flash_model_i.wd[$]);
    check("nvaddr", 26'h0000010, flash_model_i.wa[$]);
    complete_run();
  end
endmodule : tb
bind flash_cmd_host flash_cmd_checker #(.BUF_WORDS(BUF_WORDS)) chk_i (.sys_clk, .nrst,
  .cmd_valid, .cmd_op, .cmd_count, .byte_mode, .cmd_ready, .wdata_ready, .cmd_done, .cmd_error,
  .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n);
